// ### rtl/itap_pkg.sv
// Package for the indirect table access port: register indices, field
// positions, reset values, table codes and bus answer codes.
// Assumes a 32-bit AXI4-Lite bus where byte address = 4 * register index.
package itap_pkg;

  // Bus geometry
  localparam int ITAP_AXI_ADDR_W = 8;
  localparam int ITAP_AXI_DATA_W = 32;
  localparam int ITAP_IDX_LSB = 2;

  // Register indices as printed; byte address is four times the index
  localparam logic [5:0] ITAP_IDX_TOP = 6'h26;
  localparam logic [5:0] ITAP_IDX_MID_HIGH = 6'h28;
  localparam logic [5:0] ITAP_IDX_HIGH = 6'h2a;
  localparam logic [5:0] ITAP_IDX_LOW = 6'h2c;
  localparam logic [5:0] ITAP_IDX_LOW_MID = 6'h2e;
  localparam logic [5:0] ITAP_IDX_CMD = 6'h30;

  // Command word fields
  localparam int ITAP_CMD_DIR_BIT = 12;
  localparam int ITAP_CMD_TBL_LSB = 10;
  localparam int ITAP_CMD_IDX_MSB = 9;
  localparam int ITAP_CMD_W = 16;

  // Topmost data register fields
  localparam int ITAP_TOP_BUSY_BIT = 7;
  localparam int ITAP_TOP_DATA_W = 3;

  // Entry and table geometry
  localparam int ITAP_ENTRY_W = 67;
  localparam int ITAP_TBL_ADDR_W = 12;

  // Reset values
  localparam logic [15:0] ITAP_DATA16_RST = 16'h0000;
  localparam logic [15:0] ITAP_CMD_RST = 16'h0000;
  localparam logic [2:0] ITAP_TOP_RST = 3'h0;

  // Table select codes
  localparam logic [1:0] ITAP_TBL_STATIC = 2'h0;
  localparam logic [1:0] ITAP_TBL_VLAN = 2'h1;
  localparam logic [1:0] ITAP_TBL_DYNAMIC = 2'h2;
  localparam logic [1:0] ITAP_TBL_COUNTER = 2'h3;

  // AXI answer codes
  localparam logic [1:0] ITAP_RESP_OKAY = 2'h0;
  localparam logic [1:0] ITAP_RESP_SLVERR = 2'h2;

  // Access sequencer states
  typedef enum logic [1:0] {ITAP_IDLE, ITAP_ISSUE, ITAP_LOAD} itap_state_type;

endpackage : itap_pkg

// ### rtl/itap_mem_if.sv
// Interface between the access sequencer and the table memory.
// Assumes both ends run on the same clock; read data lag the strobe by one edge.
`timescale 1ns/10ps
`default_nettype none

interface itap_mem_if;
  import itap_pkg::*;
  logic we; // Write strobe
  logic re; // Read strobe
  logic [ITAP_TBL_ADDR_W-1:0] addr; // Table select and entry index
  logic [ITAP_ENTRY_W-1:0] wdata; // Entry to store
  logic [ITAP_ENTRY_W-1:0] rdata; // Registered entry read back

  modport ctrl (output we, output re, output addr, output wdata, input rdata);
  modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface : itap_mem_if

`default_nettype wire

// ### rtl/itap_table_mem.sv
// Single-port storage for the four tables, one after another in one array.
// Assumes one access per cycle; read data come out of a register next edge.
`timescale 1ns/10ps
`default_nettype none

module itap_table_mem
  import itap_pkg::*;
#(
  parameter int DATA_W = ITAP_ENTRY_W,
  parameter int ADDR_W = ITAP_TBL_ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  itap_mem_if.mem port
);

  // Refuse a geometry the interface cannot carry
  if (DATA_W != ITAP_ENTRY_W || ADDR_W != ITAP_TBL_ADDR_W) begin : g_geom_chk
    $error("itap_table_mem: width or depth differs from interface");
  end

  // Storage; contents are undefined until software writes them
  logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rdata_reg; // Read data register

  // Array write, no reset since a table of this size has none
  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (port.re) begin
      rdata_reg <= store[port.addr];
    end
  end

  assign port.rdata = rdata_reg;

endmodule : itap_table_mem

`default_nettype wire

// ### rtl/itap_indirect_port.sv
// Indirect table access port: AXI4-Lite register slave, command sequencer
// and data registers that move one entry to or from one of four tables.
// Assumes a single clock, a synchronous active-low reset and one master.
//
// Function
// - Command register write launches one table access when idle and with a low byte strobe set
// - Command bit 12: one reads, zero writes
// - Command bits 11-10 pick the table
// - Command bits 9-0 give entry index
// - Top bit 7 high during dynamic/counter reads
// - Top bits 2-0 show entry bits 66-64
// - Register 0x02A holds entry bits 63-48
// - Register 0x028 holds entry bits 47-32
// - Register 0x02E holds entry bits 31-16
// - Register 0x02C holds entry bits 15-0
`timescale 1ns/10ps
`default_nettype none

module itap_indirect_port
  import itap_pkg::*;
#(
  parameter int AXI_ADDR_W = ITAP_AXI_ADDR_W
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // Index must fit the address bus
  if (AXI_ADDR_W != ITAP_AXI_ADDR_W) begin : g_addr_chk
    $error("itap_indirect_port: address width must be 8");
  end

  // Bus slave state
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_full_reg; // Write address held
  logic w_full_reg; // Write data held
  logic [5:0] aw_idx_reg; // Held word index
  logic [15:0] wdata_reg; // Held low half of write data
  logic [1:0] wstrb_reg; // Held low byte strobes
  logic bvalid_reg;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // Block state
  logic [ITAP_CMD_W-1:0] indirect_command_reg, cmd_next;
  logic [ITAP_TOP_DATA_W-1:0] indirect_data_top_reg, top_next;
  logic [15:0] indirect_data_high_reg, high_next;
  logic [15:0] indirect_data_mid_high_reg, mid_high_next;
  logic [15:0] indirect_data_low_mid_reg, low_mid_next;
  logic [15:0] indirect_data_low_reg, low_next;
  logic read_busy_reg, busy_next; // Slow read still running
  itap_state_type state_reg, state_next;

  itap_mem_if mem_bus ();

  itap_table_mem u_mem (
    .clk (SYS_CLK),
    .rst_n (RST_N),
    .port (mem_bus.mem)
  );

  // Handshakes
  wire aw_hs = S_AXI_AWVALID && awready_reg;
  wire w_hs = S_AXI_WVALID && wready_reg;
  wire b_hs = bvalid_reg && S_AXI_BREADY;
  wire ar_hs = S_AXI_ARVALID && arready_reg;
  wire r_hs = rvalid_reg && S_AXI_RREADY;

  // A write executes once address and data are both held
  wire wr_exec = aw_full_reg && w_full_reg && !bvalid_reg;
  wire hit_top = (aw_idx_reg == ITAP_IDX_TOP);
  wire hit_high = wr_exec && (aw_idx_reg == ITAP_IDX_HIGH);
  wire hit_mid_high = wr_exec && (aw_idx_reg == ITAP_IDX_MID_HIGH);
  wire hit_low_mid = wr_exec && (aw_idx_reg == ITAP_IDX_LOW_MID);
  wire hit_low = wr_exec && (aw_idx_reg == ITAP_IDX_LOW);
  wire hit_cmd = wr_exec && (aw_idx_reg == ITAP_IDX_CMD);
  wire wr_mapped = hit_top || hit_high || hit_mid_high || hit_low_mid || hit_low
    || (aw_idx_reg == ITAP_IDX_CMD);
  wire idle = (state_reg == ITAP_IDLE);
  // Command taken only when idle; a command during an access is refused
  wire cmd_launch = hit_cmd && idle && (|wstrb_reg);
  wire cmd_refused = hit_cmd && !idle;
  wire loading = (state_reg == ITAP_LOAD);
  wire [15:0] cmd_merged = itap_merge(indirect_command_reg, wdata_reg, wstrb_reg);
  wire cmd_is_read = cmd_merged[ITAP_CMD_DIR_BIT];
  wire [1:0] cmd_tbl = cmd_merged[ITAP_CMD_TBL_LSB +: 2];
  wire slow_read = cmd_is_read && (cmd_tbl == ITAP_TBL_DYNAMIC || cmd_tbl == ITAP_TBL_COUNTER);

  // Byte-strobe merge of a 16-bit register
  function automatic logic [15:0] itap_merge(input logic [15:0] old_val,
      input logic [15:0] new_val, input logic [1:0] strb);
    itap_merge = {strb[1] ? new_val[15:8] : old_val[15:8],
                  strb[0] ? new_val[7:0] : old_val[7:0]};
  endfunction : itap_merge

  // Bus ready and response terms
  assign awready_next = aw_hs ? 1'b0 : (!aw_full_reg && !bvalid_reg) ? 1'b1 : awready_reg;
  assign wready_next = w_hs ? 1'b0 : (!w_full_reg && !bvalid_reg) ? 1'b1 : wready_reg;
  assign bresp_next = (!wr_mapped || cmd_refused) ? ITAP_RESP_SLVERR : ITAP_RESP_OKAY;
  assign arready_next = ar_hs ? 1'b0 : !rvalid_reg ? 1'b1 : arready_reg;

  // Register read selection
  wire [5:0] rd_idx = S_AXI_ARADDR[ITAP_IDX_LSB +: 6];
  wire [15:0] top_word = {8'h00, read_busy_reg, 4'h0, indirect_data_top_reg};
  wire rd_top = (rd_idx == ITAP_IDX_TOP);
  wire rd_high = (rd_idx == ITAP_IDX_HIGH);
  wire rd_mid_high = (rd_idx == ITAP_IDX_MID_HIGH);
  wire rd_low_mid = (rd_idx == ITAP_IDX_LOW_MID);
  wire rd_low = (rd_idx == ITAP_IDX_LOW);
  wire rd_cmd = (rd_idx == ITAP_IDX_CMD);
  wire [15:0] rd_word = rd_top ? top_word
    : rd_high ? indirect_data_high_reg
    : rd_mid_high ? indirect_data_mid_high_reg
    : rd_low_mid ? indirect_data_low_mid_reg
    : rd_low ? indirect_data_low_reg
    : rd_cmd ? indirect_command_reg : 16'h0000;
  wire rd_mapped = rd_top || rd_high || rd_mid_high || rd_low_mid || rd_low || rd_cmd;
  assign rdata_next = ar_hs ? {16'h0000, rd_word} : rdata_reg;
  assign rresp_next = ar_hs ? (rd_mapped ? ITAP_RESP_OKAY : ITAP_RESP_SLVERR) : rresp_reg;

  // Data registers: a table read loads them, overriding a software write
  assign high_next = loading ? mem_bus.rdata[63:48]
    : hit_high ? itap_merge(indirect_data_high_reg, wdata_reg, wstrb_reg)
    : indirect_data_high_reg;
  assign mid_high_next = loading ? mem_bus.rdata[47:32]
    : hit_mid_high ? itap_merge(indirect_data_mid_high_reg, wdata_reg, wstrb_reg)
    : indirect_data_mid_high_reg;
  assign low_mid_next = loading ? mem_bus.rdata[31:16]
    : hit_low_mid ? itap_merge(indirect_data_low_mid_reg, wdata_reg, wstrb_reg)
    : indirect_data_low_mid_reg;
  assign low_next = loading ? mem_bus.rdata[15:0]
    : hit_low ? itap_merge(indirect_data_low_reg, wdata_reg, wstrb_reg)
    : indirect_data_low_reg;
  // Top bits are read-only to software, filled only by a table read
  assign top_next = loading ? mem_bus.rdata[66:64] : indirect_data_top_reg;
  assign cmd_next = cmd_launch ? cmd_merged : indirect_command_reg;
  // Busy rises with a slow read and falls when its data land
  assign busy_next = (cmd_launch && slow_read) ? 1'b1
    : loading ? 1'b0 : read_busy_reg;

  // Sequencer: one access cycle, then a load cycle for reads
  assign state_next = cmd_launch ? ITAP_ISSUE
    : (state_reg == ITAP_ISSUE && indirect_command_reg[ITAP_CMD_DIR_BIT]) ? ITAP_LOAD
    : ITAP_IDLE;

  // Table port: write copies data registers, read fetches the entry
  assign mem_bus.we = (state_reg == ITAP_ISSUE) && !indirect_command_reg[ITAP_CMD_DIR_BIT];
  assign mem_bus.re = (state_reg == ITAP_ISSUE) && indirect_command_reg[ITAP_CMD_DIR_BIT];
  assign mem_bus.addr = indirect_command_reg[ITAP_CMD_TBL_LSB+1:0];
  assign mem_bus.wdata = {indirect_data_top_reg, indirect_data_high_reg,
    indirect_data_mid_high_reg, indirect_data_low_mid_reg, indirect_data_low_reg};

  // Write channel holding registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
    end else begin
      aw_full_reg <= aw_hs ? 1'b1 : wr_exec ? 1'b0 : aw_full_reg;
      w_full_reg <= w_hs ? 1'b1 : wr_exec ? 1'b0 : w_full_reg;
      if (aw_hs) begin
        aw_idx_reg <= S_AXI_AWADDR[ITAP_IDX_LSB +: 6];
      end
      if (w_hs) begin
        wdata_reg <= S_AXI_WDATA[15:0];
        wstrb_reg <= S_AXI_WSTRB[1:0];
      end
    end
  end

  // Bus outputs, all registered
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= ITAP_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= ITAP_RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= wr_exec ? 1'b1 : b_hs ? 1'b0 : bvalid_reg;
      bresp_reg <= wr_exec ? bresp_next : bresp_reg;
      arready_reg <= arready_next;
      rvalid_reg <= ar_hs ? 1'b1 : r_hs ? 1'b0 : rvalid_reg;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Block registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      indirect_command_reg <= ITAP_CMD_RST;
      indirect_data_top_reg <= ITAP_TOP_RST;
      indirect_data_high_reg <= ITAP_DATA16_RST;
      indirect_data_mid_high_reg <= ITAP_DATA16_RST;
      indirect_data_low_mid_reg <= ITAP_DATA16_RST;
      indirect_data_low_reg <= ITAP_DATA16_RST;
      read_busy_reg <= 1'b0;
      state_reg <= ITAP_IDLE;
    end else begin
      indirect_command_reg <= cmd_next;
      indirect_data_top_reg <= top_next;
      indirect_data_high_reg <= high_next;
      indirect_data_mid_high_reg <= mid_high_next;
      indirect_data_low_mid_reg <= low_mid_next;
      indirect_data_low_reg <= low_next;
      read_busy_reg <= busy_next;
      state_reg <= state_next;
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // Checks on the sequencer and register file
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  launch_starts_a: assert property (cmd_launch |=> state_reg == ITAP_ISSUE)
    else $error("command write did not start an access");
  dir_select_a: assert property (cmd_launch && !cmd_is_read |=> mem_bus.we && !mem_bus.re)
    else $error("write command did not write the table");
  table_select_a: assert property (cmd_launch |=> mem_bus.addr[11:10] == $past(cmd_tbl))
    else $error("wrong table selected");
  entry_index_a: assert property (cmd_launch |=> mem_bus.addr[9:0] == $past(cmd_merged[9:0]))
    else $error("wrong entry index");
  busy_window_a: assert property (cmd_launch && slow_read |=> read_busy_reg ##1 read_busy_reg
    ##1 !read_busy_reg)
    else $error("busy flag timing wrong");
  top_reserved_a: assert property (ar_hs && rd_top |=> S_AXI_RDATA[31:8] == 24'h000000
    && S_AXI_RDATA[6:3] == 4'h0 && S_AXI_RDATA[2:0] == $past(indirect_data_top_reg))
    else $error("top register layout wrong");
  high_write_a: assert property (hit_high && !loading && wstrb_reg == 2'h3
    |=> indirect_data_high_reg == $past(wdata_reg))
    else $error("bits 63-48 register not written");
  mid_high_read_a: assert property (ar_hs && rd_mid_high
    |=> S_AXI_RDATA[15:0] == $past(indirect_data_mid_high_reg))
    else $error("bits 47-32 register read wrong");
  low_mid_write_a: assert property (hit_low_mid && !loading && wstrb_reg == 2'h3
    |=> indirect_data_low_mid_reg == $past(wdata_reg))
    else $error("bits 31-16 register not written");
  low_read_a: assert property (ar_hs && rd_low
    |=> S_AXI_RDATA[15:0] == $past(indirect_data_low_reg))
    else $error("bits 15-0 register read wrong");
  load_entry_a: assert property (loading |=> {indirect_data_top_reg, indirect_data_high_reg,
    indirect_data_mid_high_reg, indirect_data_low_mid_reg, indirect_data_low_reg}
    == $past(mem_bus.rdata) && !read_busy_reg)
    else $error("read entry not loaded");
  // Bit 7 on the bus must follow the flag, or polling software would hang
  busy_shown_a: assert property (ar_hs && rd_top |=> S_AXI_RDATA[7] == $past(read_busy_reg))
    else $error("progress bit not shown on read");
  quick_idle_a: assert property (cmd_launch && !slow_read |=> !read_busy_reg)
    else $error("progress bit raised by a fast access");

  // Main scenarios
  dyn_read_c: cover property (cmd_launch && cmd_is_read && cmd_tbl == ITAP_TBL_DYNAMIC);
  counter_read_c: cover property (cmd_launch && cmd_is_read && cmd_tbl == ITAP_TBL_COUNTER);
  static_write_c: cover property (cmd_launch && !cmd_is_read && cmd_tbl == ITAP_TBL_STATIC);
  vlan_read_c: cover property (cmd_launch && cmd_is_read && cmd_tbl == ITAP_TBL_VLAN);

endmodule : itap_indirect_port

`default_nettype wire

// ### test/itap_indirect_port_tb_top.sv
// Self-checking testbench for the indirect table access port.
// Assumes the port's AXI4-Lite slave, one 25 MHz clock and a synchronous reset.
`timescale 1ns/10ps
`default_nettype none

module itap_indirect_port_tb_top;
  import itap_pkg::*;

  // Byte addresses are four times the register index
  localparam logic [7:0] A_TOP = {ITAP_IDX_TOP, 2'b00};
  localparam logic [7:0] A_MH = {ITAP_IDX_MID_HIGH, 2'b00};
  localparam logic [7:0] A_HI = {ITAP_IDX_HIGH, 2'b00};
  localparam logic [7:0] A_LO = {ITAP_IDX_LOW, 2'b00};
  localparam logic [7:0] A_LM = {ITAP_IDX_LOW_MID, 2'b00};
  localparam logic [7:0] A_CMD = {ITAP_IDX_CMD, 2'b00};
  localparam logic [7:0] A_HOLE = 8'h9c; // Index 0x27 sits between two registers

  logic clk; // System clock
  logic rst_n; // Active-low reset
  logic [7:0] awaddr; // Write address
  logic [7:0] araddr; // Read address
  logic [31:0] wdata; // Write data
  logic [3:0] wstrb; // Byte strobes
  logic awvalid, wvalid, bready, arvalid, rready; // Master handshakes
  logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
  logic [1:0] bresp; // Write answer
  logic [1:0] rresp; // Read answer
  logic [31:0] rdata; // Read data
  int fail_count; // Mismatches seen
  int n_checks; // Comparisons made

  itap_indirect_port dut (
    .SYS_CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  // Free-running 40 ns clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Counts and verdict, the single end of the run
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // One comparison; four-state so an unknown never matches
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // A hung handshake counts as a mismatch and closes the run
  task stall(input string msg);
    fail_count++;
    $display("wrong value at %0t: %s never answered", $time, msg);
    give_verdict();
  endtask : stall

  // AXI4-Lite write; a fresh edge first so no signal is set twice in a step
  task axi_write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                 output logic [1:0] resp);
    bit done;
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 0;
    for (i = 0; i < 50 && !done; i++) begin
      @(posedge clk);
      if (awready === 1'b1 && awvalid === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1 && wvalid === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) stall("write");
  endtask : axi_write

  // AXI4-Lite read; rready held until rvalid is sampled
  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit done;
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 0;
    for (i = 0; i < 50 && !done; i++) begin
      @(posedge clk);
      if (arready === 1'b1 && arvalid === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) stall("read");
  endtask : axi_read

  // Two-byte write (strobes 0 and 1) that must be answered OKAY
  task wr_ok(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'h3, r);
    check({30'h0, r}, {30'h0, ITAP_RESP_OKAY}, "write answer");
  endtask : wr_ok

  // Read that must answer OKAY with the expected word
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check({30'h0, r}, {30'h0, ITAP_RESP_OKAY}, "read answer");
    check(d, exp, msg);
  endtask : rd_chk

  // Load the four writable data registers
  task set_data(input logic [15:0] hi, input logic [15:0] mh, input logic [15:0] lm,
                input logic [15:0] lo);
    wr_ok(A_HI, hi);
    wr_ok(A_MH, mh);
    wr_ok(A_LM, lm);
    wr_ok(A_LO, lo);
  endtask : set_data

  // All registers read zero out of reset
  task test_reset;
    rd_chk(A_TOP, 32'h0, "top after reset");
    rd_chk(A_MH, 32'h0, "bits 47:32 after reset");
    rd_chk(A_HI, 32'h0, "bits 63:48 after reset");
    rd_chk(A_LO, 32'h0, "bits 15:0 after reset");
    rd_chk(A_LM, 32'h0, "bits 31:16 after reset");
    rd_chk(A_CMD, 32'h0, "command after reset");
    $display("test reset done");
  endtask : test_reset

  // Each data register keeps its own value; the top one cannot be written
  task test_data_rw;
    logic [1:0] r;
    set_data(16'h1357, 16'h2468, 16'h9bdf, 16'h1234);
    wr_ok(A_TOP, 16'hffff);
    axi_write(A_LO, 16'habcd, 4'h1, r); // Only the low byte lands
    check({30'h0, r}, {30'h0, ITAP_RESP_OKAY}, "byte write answer");
    rd_chk(A_HI, 32'h1357, "bits 63:48 readback");
    rd_chk(A_MH, 32'h2468, "bits 47:32 readback");
    rd_chk(A_LM, 32'h9bdf, "bits 31:16 readback");
    rd_chk(A_LO, 32'h12cd, "bits 15:0 byte write");
    rd_chk(A_TOP, 32'h0, "top stays read-only");
    $display("test data registers done");
  endtask : test_data_rw

  // A hole in the map is refused both ways
  task test_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    axi_write(A_HOLE, 16'h5555, 4'h3, r);
    check({30'h0, r}, {30'h0, ITAP_RESP_SLVERR}, "unmapped write answer");
    axi_read(A_HOLE, d, r);
    check({30'h0, r}, {30'h0, ITAP_RESP_SLVERR}, "unmapped read answer");
    check(d, 32'h0, "unmapped read data");
    $display("test unmapped done");
  endtask : test_unmapped

  // Store five entries across all tables and index limits, then read each back
  task test_tables;
    logic [1:0] tsel [5];
    logic [9:0] idx [5];
    logic [15:0] cmd;
    logic [31:0] d;
    logic [1:0] r;
    int k;
    int n;
    tsel = '{ITAP_TBL_STATIC, ITAP_TBL_VLAN, ITAP_TBL_DYNAMIC, ITAP_TBL_COUNTER,
             ITAP_TBL_STATIC};
    idx = '{10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff, 10'h000};
    // Same index in every table, so a lost table select shows up as a clash
    for (k = 0; k < 5; k++) begin
      set_data(16'ha000 + 16'(k), 16'hb000 + 16'(k), 16'hc000 + 16'(k), 16'hd000 + 16'(k));
      wr_ok(A_CMD, {3'h0, 1'b0, tsel[k], idx[k]});
    end
    for (k = 0; k < 5; k++) begin
      set_data(16'h0000, 16'h0000, 16'h0000, 16'h0000); // Stale data must be replaced
      cmd = {3'h5, 1'b1, tsel[k], idx[k]};
      wr_ok(A_CMD, cmd);
      // Poll the progress flag under a bound before trusting the data
      d = 32'h80;
      for (n = 0; n < 20 && d[ITAP_TOP_BUSY_BIT] !== 1'b0; n++) begin
        axi_read(A_TOP, d, r);
      end
      check(d, 32'h0, "top after read done");
      rd_chk(A_HI, 32'ha000 + k, "entry bits 63:48");
      rd_chk(A_MH, 32'hb000 + k, "entry bits 47:32");
      rd_chk(A_LM, 32'hc000 + k, "entry bits 31:16");
      rd_chk(A_LO, 32'hd000 + k, "entry bits 15:0");
      rd_chk(A_CMD, {16'h0, cmd}, "command readback");
    end
    $display("test tables done");
  endtask : test_tables

  // A top read in flight while a slow read runs must show bit 7 set
  task test_busy;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    d = 32'h0;
    fork
      wr_ok(A_CMD, {3'h0, 1'b1, ITAP_TBL_DYNAMIC, 10'h3ff});
      begin
        // Issue the read one edge after the command data are taken
        for (n = 0; n < 50 && !(wvalid === 1'b1 && wready === 1'b1); n++) @(posedge clk);
        axi_read(A_TOP, d, r);
      end
    join
    check({30'h0, r}, {30'h0, ITAP_RESP_OKAY}, "busy read answer");
    check(d, 32'h80, "top while read runs");
    $display("test busy done");
  endtask : test_busy

  // Main sequence: quiet inputs, eight reset cycles, then the scenarios
  initial begin
    fail_count = 0;
    n_checks = 0;
    rst_n = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_data_rw();
    test_unmapped();
    test_tables();
    test_busy();
    give_verdict();
  end

endmodule : itap_indirect_port_tb_top

`default_nettype wire
